/* mmbw_defines.vh */
// Purpose: constants for the memory map and write-protect block
// Assumes: 16-bit cpu address, 8-bit data
// Notes: offsets are cpu byte addresses
`ifndef MMBW_DEFINES_VH
`define MMBW_DEFINES_VH
`define MMBW_RAM_ALIAS_LO 16'h0000
`define MMBW_RAM_ALIAS_HI 16'h007F
`define MMBW_RAM_BASE 16'h0100
`define MMBW_RAM_TOP 16'h01FF
`define MMBW_SFR_LO 16'h00C0
`define MMBW_SFR_HI 16'h00FF
`define MMBW_BANK_LO 16'h4000
`define MMBW_BANK_HI 16'h7FFF
`define MMBW_FIXED_LO 16'h8000
`define MMBW_OFF_CLKMGR 16'h00C0
`define MMBW_OFF_SYSCLR 16'h00C1
`define MMBW_OFF_BANK 16'h00F2
`define MMBW_OFF_KEY 16'h00F3
`define MMBW_UNLOCK_PATTERN 8'h58
`define MMBW_BANK_RESET 1'h0
`define MMBW_CLKMGR_RESET 8'h00
`define MMBW_WDT_CLR_BIT 6
`define MMBW_REG_RESET_DATA 8'h00
`define MMBW_SEL_NONE 3'h0
`define MMBW_SEL_RAM 3'h1
`define MMBW_SEL_SFR 3'h2
`define MMBW_SEL_BANK 3'h3
`define MMBW_SEL_FIXED 3'h4
`endif

/* mmbw_memory_map_bank_write_protect.v */
// Purpose: cpu address decode, rom bank select, write-protect key and program counter
// Assumes: cpu issues one access per cycle with memRd/memWr strobes
// Notes: decode outputs are registered, so they follow the access by one cycle
//
// Contract
// (R01) 0000H-007FH aliases the 0100H RAM range
// (R02) 00C0H-00FFH goes to special register space
// (R03) 8000H-FFFFH maps fixed ROM, bank independent
// (R04) 64K ROM: 32K fixed plus banked
// (R05) 4000H-7FFFH selects one of two banks
// (R06) bank select resets to zero
// (R07) bank register 00F2H read/write, bit 0
// (R08) key 00F3H write-only; 58H unlocks
// (R09) key guards watchdog clear and clock manager
// (R10) key clears after the next write
// (R11) software uses byte writes on key only
// (R12) program counter drives address high/low bytes
// (R13) program counter increments per program fetch
// (R14) firmware initialises stack pointer itself
// (R15) software writes key then protected register
// (R16) unkeyed protected writes are ignored
`timescale 1ns/1ps
`include "mmbw_defines.vh"
module mmbw_memory_map_bank_write_protect #(
  parameter ROM_ADDR_W = 16
) (
  input wire core_clk,
  input wire sys_rst,
  input wire [15:0] cpuAddr,
  input wire [7:0] cpuWrData,
  input wire memRd,
  input wire memWr,
  input wire pcFetch,
  input wire pcLoad,
  input wire [15:0] pcLoadValue,
  output reg [15:0] fetchAddr,
  output reg [2:0] regionSel,
  output reg [8:0] ramIndex,
  output reg [ROM_ADDR_W-1:0] romAddr,
  output reg [5:0] sfrIndex,
  output reg [7:0] sfrRdData,
  output reg sfrRdOwn,
  output reg [7:0] mainClockManagerReg,
  output reg watchdogClearPulse,
  output reg bankSelectBit
);

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  reg [2:0] sel_nxt;
  reg [8:0] ram_nxt;
  reg [ROM_ADDR_W-1:0] rom_nxt;
  always @* begin
    sel_nxt = `MMBW_SEL_NONE;
    ram_nxt = 9'h000;
    rom_nxt = {ROM_ADDR_W{1'b0}};
    if (cpuAddr >= `MMBW_FIXED_LO) begin
      sel_nxt = `MMBW_SEL_FIXED; // see (R03)
      rom_nxt = {1'b0, cpuAddr[14:0]}; // see (R04)
    end else if (cpuAddr >= `MMBW_BANK_LO && cpuAddr <= `MMBW_BANK_HI) begin
      sel_nxt = `MMBW_SEL_BANK;
      // banks sit above the 32K fixed region in the 64K rom
      rom_nxt = {1'b1, bankSelectBit, cpuAddr[13:0]}; // see (R05) see (R04)
    end else if (cpuAddr >= `MMBW_SFR_LO && cpuAddr <= `MMBW_SFR_HI) begin
      sel_nxt = `MMBW_SEL_SFR; // see (R02)
    end else if (cpuAddr <= `MMBW_RAM_ALIAS_HI) begin
      sel_nxt = `MMBW_SEL_RAM;
      ram_nxt = {1'b1, cpuAddr[7:0]}; // see (R01)
    end else if (cpuAddr >= `MMBW_RAM_BASE && cpuAddr <= `MMBW_RAM_TOP) begin
      sel_nxt = `MMBW_SEL_RAM;
      ram_nxt = cpuAddr[8:0];
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  wire hitKey;
  wire hitBank;
  wire hitClk;
  wire hitSys;
  wire wrKey;
  wire wrBank;
  wire wrClk;
  wire wrSys;
  wire rdBank;
  wire rdKey;
  wire keyMatch;

  assign hitKey = (cpuAddr == `MMBW_OFF_KEY);
  assign hitBank = (cpuAddr == `MMBW_OFF_BANK);
  assign hitClk = (cpuAddr == `MMBW_OFF_CLKMGR);
  assign hitSys = (cpuAddr == `MMBW_OFF_SYSCLR);
  assign wrKey = memWr && hitKey;
  assign wrBank = memWr && hitBank;
  assign wrClk = memWr && hitClk;
  assign wrSys = memWr && hitSys;
  assign rdBank = memRd && hitBank;
  assign rdKey = memRd && hitKey;
  // key compares a whole byte; a stray bit op can only fail to unlock
  assign keyMatch = (cpuWrData == `MMBW_UNLOCK_PATTERN); // see (R08) see (R11)

  // ------------------------------------------------------------
  // decode outputs
  // ------------------------------------------------------------
  // registered so the downstream memories see a clean select
  always @(posedge core_clk) begin
    if (sys_rst) begin
      regionSel <= `MMBW_SEL_NONE;
      ramIndex <= 9'h000;
      romAddr <= {ROM_ADDR_W{1'b0}};
      sfrIndex <= 6'h00;
    end else begin
      regionSel <= sel_nxt;
      ramIndex <= ram_nxt;
      romAddr <= rom_nxt;
      sfrIndex <= cpuAddr[5:0];
    end
  end

  // ------------------------------------------------------------
  // bank select
  // ------------------------------------------------------------
  always @(posedge core_clk) begin
    if (sys_rst) begin
      bankSelectBit <= `MMBW_BANK_RESET; // see (R06)
    end else begin
      if (wrBank) begin
        bankSelectBit <= cpuWrData[0]; // see (R07)
      end
    end
  end

  // ------------------------------------------------------------
  // write-protect key
  // ------------------------------------------------------------
  reg keyOk_r;
  reg keyOk_nxt;

  // any write that is not the key itself spends the unlock
  always @* begin
    keyOk_nxt = keyOk_r;
    if (wrKey) begin
      keyOk_nxt = keyMatch; // see (R08)
    end else if (memWr) begin
      keyOk_nxt = 1'b0; // see (R10)
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      keyOk_r <= 1'b0;
    end else begin
      keyOk_r <= keyOk_nxt;
    end
  end

  // ------------------------------------------------------------
  // protected registers
  // ------------------------------------------------------------
  wire clkWrOk;
  wire wdtFire;

  assign clkWrOk = wrClk && keyOk_r; // see (R09) see (R16)
  assign wdtFire = wrSys && keyOk_r && cpuWrData[`MMBW_WDT_CLR_BIT]; // see (R09) see (R16)

  always @(posedge core_clk) begin
    if (sys_rst) begin
      mainClockManagerReg <= `MMBW_CLKMGR_RESET;
    end else begin
      if (clkWrOk) begin
        mainClockManagerReg <= cpuWrData;
      end
    end
  end

  // pulse lasts one cycle; the watchdog itself lives outside
  always @(posedge core_clk) begin
    if (sys_rst) begin
      watchdogClearPulse <= 1'b0;
    end else begin
      watchdogClearPulse <= wdtFire;
    end
  end

  // ------------------------------------------------------------
  // read-back
  // ------------------------------------------------------------
  wire [7:0] bankWord;
  wire [7:0] rdData_nxt;

  // reserved bank bits read as zero
  assign bankWord = {7'h00, bankSelectBit};

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : gen_rd_bit
      assign rdData_nxt[gi] = rdBank & bankWord[gi]; // see (R07)
    end
  endgenerate

  // key register is write-only and reads as zero
  always @(posedge core_clk) begin
    if (sys_rst) begin
      sfrRdData <= `MMBW_REG_RESET_DATA;
      sfrRdOwn <= 1'b0;
    end else begin
      sfrRdData <= rdData_nxt;
      sfrRdOwn <= rdBank || rdKey;
    end
  end

  // ------------------------------------------------------------
  // program counter
  // ------------------------------------------------------------
  reg [15:0] pc_r;
  reg [15:0] pc_nxt;

  // a load wins over a fetch in the same cycle
  always @* begin
    pc_nxt = pc_r;
    if (pcLoad) begin
      pc_nxt = pcLoadValue;
    end else if (pcFetch) begin
      pc_nxt = pc_r + 16'h0001; // see (R13)
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      pc_r <= 16'h0000;
      fetchAddr <= 16'h0000;
    end else begin
      pc_r <= pc_nxt;
      fetchAddr <= pc_nxt;
    end
  end
  // fetchAddr carries program_counter_high on [15:8], low on [7:0]; see (R12)

endmodule // mmbw_memory_map_bank_write_protect

/* mmbw_asserts.sv */
`timescale 1ns/1ps
// Purpose: port checker; Assumes: one access per cycle; Notes: p* regs keep the last cycle's request
module mmbw_asserts #(parameter ROM_ADDR_W=16)(input wire core_clk,sys_rst,memRd,memWr,pcFetch,pcLoad,
  watchdogClearPulse,bankSelectBit,sfrRdOwn,input wire [15:0] cpuAddr,pcLoadValue,fetchAddr,
  input wire [7:0] cpuWrData,sfrRdData,mainClockManagerReg,input wire [2:0] regionSel,
  input wire [8:0] ramIndex,input wire [ROM_ADDR_W-1:0] romAddr,input wire [5:0] sfrIndex);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic [15:0] pA;
  logic [7:0] pD;
  logic pS,pW,keyOk;
  // key state tracked here so a stuck key in the design cannot hide
  always @(posedge core_clk) begin
    pA<=cpuAddr;
    pD<=cpuWrData;
    pS<=!sys_rst&&(memRd||memWr);
    pW<=!sys_rst&&memWr;
    if (sys_rst) keyOk<=1'b0;
    else if (memWr) keyOk<=cpuAddr==16'h00F3&&cpuWrData==8'h58;
  end
  ram_alias_a: assert property (pS&&pA<=16'h007F |-> regionSel==3'h1&&ramIndex=={1'b1,pA[7:0]})
    else $error("ram");
  sfr_route_a: assert property (pS&&pA[15:6]==10'h003 |-> regionSel==3'h2&&sfrIndex==pA[5:0])
    else $error("sfr");
  fixed_rom_a: assert property (pS&&pA[15] |-> regionSel==3'h4&&romAddr=={1'b0,pA[14:0]})
    else $error("rom");
  bank_win_a: assert property (pS&&pA[15:14]==2'h1 |-> romAddr=={1'b1,$past(bankSelectBit),pA[13:0]})
    else $error("win");
  bank_reset_a: assert property ($past(sys_rst) |-> !bankSelectBit)
    else $error("rst");
  bank_write_a: assert property (pW&&pA==16'h00F2 |-> bankSelectBit==pD[0])
    else $error("bank");
  clk_mgr_a: assert property (pW&&pA==16'h00C0 |->
    mainClockManagerReg==($past(keyOk)?pD:$past(mainClockManagerReg))) else $error("mcm");
  wdt_pulse_a: assert property (pW&&pA==16'h00C1 |->
    watchdogClearPulse==($past(keyOk)&&pD[6]) ##1 !watchdogClearPulse) else $error("wdt");
  pc_step_a: assert property ($past(pcFetch&&!pcLoad) |-> fetchAddr==$past(fetchAddr)+16'h1)
    else $error("pc");
  cover property (watchdogClearPulse);
  cover property (regionSel==3'h3);
  cover property (pW&&pA==16'h00C0&&$past(keyOk));
endmodule // mmbw_asserts
bind mmbw_memory_map_bank_write_protect mmbw_asserts #(.ROM_ADDR_W(ROM_ADDR_W)) chk(.*);

/* mmbw_cpu_model.sv */
`timescale 1ns/1ps
// Purpose: cpu bus model; Assumes: byte writes only; Notes: data bus inverts when idle
module mmbw_cpu_model(input wire core_clk,output logic [15:0] cpuAddr=16'h0,output logic [7:0] cpuWrData=8'h0,
  output logic memRd=1'b0,output logic memWr=1'b0);
  task acc(input logic wr,input logic [15:0] a,input logic [7:0] d);
    @(posedge core_clk); memWr<=wr; memRd<=!wr; cpuAddr<=a; cpuWrData<=d;
    @(posedge core_clk); memWr<=1'b0; memRd<=1'b0; cpuWrData<=~d;
  endtask
endmodule // mmbw_cpu_model

/* memory_map_bank_write_protect_bench.sv */
`timescale 1ns/1ps
// Purpose: bench; Assumes: cpu model drives the bus; Notes: one idle cycle per access
module memory_map_bank_write_protect_bench;
  logic core_clk=1'b0,sys_rst=1'b1,pcFetch=1'b0,pcLoad=1'b0,memRd,memWr,sfrRdOwn,watchdogClearPulse,bankSelectBit;
  logic [15:0] pcLoadValue=16'h1234,cpuAddr,fetchAddr,romAddr;
  logic [7:0] cpuWrData,sfrRdData,mainClockManagerReg;
  logic [2:0] regionSel;
  logic [8:0] ramIndex;
  logic [5:0] sfrIndex;
  int n_mismatch=0,check_count=0,t=0;
  logic [18:0] rows[4]='{{16'h017F,3'h1},{16'h00C0,3'h2},{16'h4000,3'h3},{16'hFFFF,3'h4}};
  mmbw_memory_map_bank_write_protect dut(.*);
  mmbw_cpu_model cpu(.*);
  initial forever #25 core_clk=~core_clk;
  always @(posedge core_clk) if (++t==300) begin n_mismatch++; print_verdict; end
  task print_verdict;
    if (n_mismatch==0&&check_count>0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input string n,input logic [15:0] s,e);
    check_count++;
    if (s!==e) begin n_mismatch++; $display("CHECK FAILED %s exp %h got %h",n,e,s); end
  endtask
  task w(input logic [15:0] a,input logic [7:0] d); cpu.acc(1'b1,a,d); #1; endtask
  initial begin
    repeat(5) @(posedge core_clk); sys_rst<=1'b0; #1;
    chk("bank",bankSelectBit,16'h0);
    foreach (rows[i]) begin cpu.acc(1'b0,rows[i][18:3],8'h0); #1 chk("region",regionSel,rows[i][2:0]); end
    w(16'h00C0,8'h06); chk("mcm",mainClockManagerReg,16'h0);
    w(16'h00F3,8'h58); w(16'h00F2,8'h01); w(16'h00C0,8'h06); chk("mcm",mainClockManagerReg,16'h0);
    cpu.acc(1'b0,16'h00F2,8'h0); #1 chk("bankrd",{sfrRdOwn,sfrRdData},16'h101);
    cpu.acc(1'b0,16'h4000,8'h0); #1 chk("bankrom",romAddr,16'hC000);
    cpu.acc(1'b0,16'h8000,8'h0); #1 chk("fixrom",romAddr,16'h0000);
    cpu.acc(1'b0,16'h007F,8'h0); #1 chk("alias",ramIndex,16'h017F);
    cpu.acc(1'b0,16'h00F3,8'h0); #1 chk("keyrd",{sfrRdOwn,sfrRdData},16'h100);
    w(16'h00F3,8'h57); w(16'h00C0,8'h06); chk("mcm",mainClockManagerReg,16'h0);
    w(16'h00F3,8'h58); w(16'h00C0,8'h06); chk("mcm",mainClockManagerReg,16'h6);
    w(16'h00F3,8'h58); w(16'h00C1,8'h40); chk("wdt",watchdogClearPulse,16'h1);
    @(posedge core_clk); sys_rst<=1'b1; @(posedge core_clk); sys_rst<=1'b0; #1;
    chk("bankrst",bankSelectBit,16'h0);
    chk("mcmrst",mainClockManagerReg,16'h0);
    @(posedge core_clk); pcLoad<=1'b1; @(posedge core_clk); pcLoad<=1'b0; pcFetch<=1'b1;
    repeat(2) @(posedge core_clk); pcFetch<=1'b0; #1 chk("pc",fetchAddr,16'h1236);
    print_verdict;
  end
endmodule // memory_map_bank_write_protect_bench
